/* File: design/tcc_pkg.sv */
// Constants, types and register map of the timer channel coprocessor.
package tcc_pkg;
   // ==========================================================
   // Sizes
   localparam int TCC_CHANS = 16;
   localparam int TCC_TBW = 16;
   localparam int TCC_RAM_WORDS = 128;
   localparam int TCC_RAM_LWORDS = 64;
   localparam int TCC_P_SMALL = 6;
   localparam int TCC_P_BIG = 8;
   localparam int TCC_P_BIG_CH = 14;
   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] TCC_A_CFG = 12'h000;
   localparam logic [11:0] TCC_A_FSEL = 12'h004;
   localparam logic [11:0] TCC_A_TBSEL = 12'h008;
   localparam logic [11:0] TCC_A_HSR = 12'h00c;
   localparam logic [11:0] TCC_A_PRIO = 12'h010;
   localparam logic [11:0] TCC_A_LINK = 12'h014;
   localparam logic [11:0] TCC_A_STAT = 12'h018;
   localparam logic [3:0] TCC_A_RAM_PAGE = 4'h1;
   // ==========================================================
   // Configuration fields and reset values
   localparam int TCC_CFG_PS1_LSB = 0;
   localparam int TCC_CFG_PS2_LSB = 3;
   localparam int TCC_CFG_TB2_EXT = 6;
   localparam int TCC_CFG_RAM_SRC = 7;
   localparam logic [7:0] TCC_CFG_RST = 8'h00;
   localparam logic [31:0] TCC_FSEL_RST = 32'h0000_0000;
   localparam logic [31:0] TCC_TBSEL_RST = 32'h0000_0000;
   localparam logic [31:0] TCC_PRIO_RST = 32'h0000_0000;
   localparam logic [3:0] TCC_LAST_RST = 4'hf;
   // ==========================================================
   // Channel functions and priority levels
   localparam logic [1:0] TCC_FN_NONE = 2'h0;
   localparam logic [1:0] TCC_FN_MATCH = 2'h1;
   localparam logic [1:0] TCC_FN_CAPT = 2'h2;
   localparam logic [1:0] TCC_FN_LINKM = 2'h3;
   localparam logic [1:0] TCC_PRI_OFF = 2'h0;
   localparam logic [1:0] TCC_PRI_LOW = 2'h1;
   localparam logic [1:0] TCC_PRI_MID = 2'h2;
   localparam logic [1:0] TCC_PRI_HIGH = 2'h3;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      TCC_ST_IDLE = 3'b001,
      TCC_ST_FETCH = 3'b010,
      TCC_ST_EXEC = 3'b100
   } tcc_st_e;
   typedef struct packed {
      logic ram_src;
      logic tb2_ext;
      logic [2:0] ps2;
      logic [2:0] ps1;
   } tcc_cfg_s;
   typedef struct packed {
      logic hsr;
      logic link;
      logic match;
      logic capt;
   } tcc_cause_s;
endpackage : tcc_pkg

/* File: design/tcc_top.sv */
// Timer channel coprocessor core: time bases, channels, scheduler, engine.
`timescale 1ns/100ps
`default_nettype none
module tcc_top
   import tcc_pkg::*;
#(
   parameter int NCH = tcc_pkg::TCC_CHANS
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Channel pins and external time base clock.
   input wire logic [NCH-1:0] ch_pin_i,
   output logic [NCH-1:0] ch_pin_o,
   output logic [NCH-1:0] ch_pin_oe,
   input wire logic external_time_base_clock_pin,
   // Microcode source indication.
   output logic ucode_from_ram
);
   import tcc_pkg::*;

   if (NCH != TCC_CHANS) begin : g_bad_nch
      $error("Channel count must be sixteen for the parameter layout.");
   end

   // ==========================================================
   // Functions
   function automatic logic pre_tick(input logic [7:0] c, input logic [2:0] ps);
      logic [7:0] m;
      m = (8'h01 << ps) - 8'h01;
      pre_tick = (c & m) == m;
   endfunction : pre_tick

   // Rotating search: first set bit after the last served channel.
   function automatic logic [3:0] rr_pick(input logic [15:0] m, input logic [3:0] last);
      logic [3:0] idx;
      rr_pick = last;
      for (int k = 16; k >= 1; k--) begin
         idx = last + 4'(k);
         if (m[idx]) begin
            rr_pick = idx;
         end
      end
   endfunction : rr_pick

   function automatic logic [6:0] pbase(input logic [3:0] c);
      if (c < 4'(TCC_P_BIG_CH)) begin
         pbase = 7'(int'(c) * TCC_P_SMALL);
      end else begin
         pbase = 7'(TCC_P_BIG_CH * TCC_P_SMALL + (int'(c) - TCC_P_BIG_CH) * TCC_P_BIG);
      end
   endfunction : pbase

   // ==========================================================
   // Registers and state
   tcc_cfg_s cfg_reg;
   logic [31:0] fsel_reg, tbsel_reg, prio_reg;
   logic [15:0] hsr_reg, link_reg, mflag_reg, cflag_reg, armed_reg;
   logic [15:0] match_reg [NCH];
   logic [15:0] cap_reg [NCH];
   logic [15:0] tb1_reg, tb2_reg;
   logic [7:0] div1_reg, div2_reg;
   logic [NCH-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
   logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
   logic [3:0] last_reg [3];
   tcc_st_e st_reg;
   logic [3:0] ch_reg;
   tcc_cause_s cause_reg;
   logic [15:0] pw_reg;
   logic [31:0] ram [TCC_RAM_LWORDS];
   logic [31:0] prdata_reg;
   logic pready_reg, pslverr_reg;
   logic [NCH-1:0] pin_o_reg, pin_oe_reg;
   logic ucode_reg;

   // ==========================================================
   // Time bases
   wire ext_edge = ext_s2_reg & ~ext_s3_reg;
   wire tb2_src = cfg_reg.tb2_ext ? ext_edge : 1'b1;
   wire tb1_tick = pre_tick(div1_reg, cfg_reg.ps1);
   wire tb2_tick = tb2_src & pre_tick(div2_reg, cfg_reg.ps2);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div1_reg <= 8'h00;
         div2_reg <= 8'h00;
         tb1_reg <= 16'h0000;
         tb2_reg <= 16'h0000;
      end else begin
         div1_reg <= div1_reg + 8'h01;
         if (tb2_src) begin
            div2_reg <= div2_reg + 8'h01;
         end
         if (tb1_tick) begin
            tb1_reg <= tb1_reg + 16'h0001;
         end
         if (tb2_tick) begin
            tb2_reg <= tb2_reg + 16'h0001;
         end
      end
   end

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {pin_s1_reg, pin_s2_reg, pin_s3_reg} <= '0;
         {ext_s1_reg, ext_s2_reg, ext_s3_reg} <= 3'h0;
      end else begin
         pin_s1_reg <= ch_pin_i;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         ext_s1_reg <= external_time_base_clock_pin;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
      end
   end

   // ==========================================================
   // Channel event hardware
   logic [15:0] mtb [NCH];
   logic [15:0] ctb [NCH];
   logic [1:0] fn [NCH];
   logic [1:0] pri [NCH];
   logic [NCH-1:0] match_hit, cap_edge, pend;
   logic [NCH-1:0] m_hi, m_mid, m_low;
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign fn[i] = fsel_reg[2*i +: 2];
      assign pri[i] = prio_reg[2*i +: 2];
      assign mtb[i] = tbsel_reg[i] ? tb2_reg : tb1_reg;
      assign ctb[i] = tbsel_reg[16+i] ? tb2_reg : tb1_reg;
      assign match_hit[i] = armed_reg[i] & (mtb[i] >= match_reg[i]);
      assign cap_edge[i] = ~pin_oe_reg[i] & (fn[i] == TCC_FN_CAPT) & pin_s2_reg[i] & ~pin_s3_reg[i];
      assign pend[i] = (hsr_reg[i] | link_reg[i] | mflag_reg[i] | cflag_reg[i])
         & (pri[i] != TCC_PRI_OFF);
      assign m_hi[i] = pend[i] & (pri[i] == TCC_PRI_HIGH);
      assign m_mid[i] = pend[i] & (pri[i] == TCC_PRI_MID);
      assign m_low[i] = pend[i] & (pri[i] == TCC_PRI_LOW);
   end

   // ==========================================================
   // Scheduler
   wire [1:0] lvl = (|m_hi) ? 2'd2 : (|m_mid) ? 2'd1 : 2'd0;
   wire [15:0] top_m = (|m_hi) ? m_hi : (|m_mid) ? m_mid : m_low;
   wire [3:0] pick = rr_pick(top_m, last_reg[lvl]);
   wire svc_start = (st_reg == TCC_ST_IDLE) & (|pend);
   wire [15:0] grant_oh = {15'h0, svc_start} << pick;

   // ==========================================================
   // Engine
   wire in_exec = st_reg == TCC_ST_EXEC;
   wire [1:0] cfn = fn[ch_reg];
   wire out_fn = (cfn == TCC_FN_MATCH) | (cfn == TCC_FN_LINKM);
   wire arm = in_exec & out_fn & (cause_reg.hsr | cause_reg.link | cause_reg.match);
   wire [15:0] arm_oh = {15'h0, arm} << ch_reg;
   wire do_link = in_exec & cause_reg.match & (cfn == TCC_FN_LINKM);
   wire [15:0] link_oh = {15'h0, do_link} << (ch_reg + 4'h1);
   wire [6:0] pw_addr = pbase(ch_reg);
   wire [6:0] res_addr = pw_addr + 7'h01;
   wire [31:0] pw_lw = ram[pw_addr[6:1]];
   wire eng_wr = in_exec & cause_reg.capt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= TCC_ST_IDLE;
         ch_reg <= 4'h0;
         cause_reg <= '0;
         pw_reg <= 16'h0000;
         last_reg <= '{default: TCC_LAST_RST};
         ucode_reg <= 1'b0;
      end else begin
         ucode_reg <= cfg_reg.ram_src & (svc_start | (st_reg == TCC_ST_FETCH));
         case (st_reg)
            TCC_ST_IDLE: begin
               if (svc_start) begin
                  st_reg <= TCC_ST_FETCH;
                  ch_reg <= pick;
                  last_reg[lvl] <= pick;
                  cause_reg <= '{hsr_reg[pick], link_reg[pick], mflag_reg[pick], cflag_reg[pick]};
               end
            end
            TCC_ST_FETCH: begin
               st_reg <= TCC_ST_EXEC;
               pw_reg <= pw_addr[0] ? pw_lw[15:0] : pw_lw[31:16];
            end
            TCC_ST_EXEC: begin
               st_reg <= TCC_ST_IDLE;
            end
            default: begin
               st_reg <= TCC_ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Request flags: a new event in the grant cycle wins over the clear.
   wire host_acc = psel & penable & pready_reg;
   wire host_wr = host_acc & pwrite;
   wire [15:0] hsr_set = (host_wr && paddr == TCC_A_HSR) ? pwdata[15:0] : 16'h0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {hsr_reg, link_reg, mflag_reg, cflag_reg, armed_reg} <= '0;
      end else begin
         hsr_reg <= (hsr_reg & ~grant_oh) | hsr_set;
         link_reg <= (link_reg & ~grant_oh) | link_oh;
         mflag_reg <= (mflag_reg & ~grant_oh) | match_hit;
         cflag_reg <= (cflag_reg & ~grant_oh) | cap_edge;
         armed_reg <= (armed_reg & ~match_hit) | arm_oh;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_reg <= '{default: 16'h0000};
         cap_reg <= '{default: 16'h0000};
         pin_o_reg <= '0;
         pin_oe_reg <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (cap_edge[i]) begin
               cap_reg[i] <= ctb[i];
            end
         end
         if (arm) begin
            match_reg[ch_reg] <= mtb[ch_reg] + pw_reg;
         end
         if (in_exec) begin
            pin_oe_reg[ch_reg] <= out_fn;
            if (cause_reg.match & out_fn) begin
               pin_o_reg[ch_reg] <= ~pin_o_reg[ch_reg];
            end
         end
      end
   end

   // ==========================================================
   // Parameter RAM: each bus word holds an even and odd parameter.
   wire ram_hit = paddr[11:8] == TCC_A_RAM_PAGE;
   always_ff @(posedge pclk) begin
      if (eng_wr) begin
         if (res_addr[0]) begin
            ram[res_addr[6:1]][15:0] <= cap_reg[ch_reg];
         end else begin
            ram[res_addr[6:1]][31:16] <= cap_reg[ch_reg];
         end
      end
      if (host_wr & ram_hit) begin
         ram[paddr[7:2]] <= pwdata;
      end
   end

   // ==========================================================
   // APB slave: one wait state, read data taken from a register.
   wire reg_hit = (paddr == TCC_A_CFG) | (paddr == TCC_A_FSEL) | (paddr == TCC_A_TBSEL)
      | (paddr == TCC_A_HSR) | (paddr == TCC_A_PRIO) | (paddr == TCC_A_LINK)
      | (paddr == TCC_A_STAT);
   wire addr_ok = ram_hit | reg_hit;
   wire [31:0] stat_v = {pin_s2_reg, 11'h000, st_reg != TCC_ST_IDLE, ch_reg};
   // The time bases have no address, so the host can never read them.
   wire [31:0] rd_mux = ram_hit ? ram[paddr[7:2]] :
      (paddr == TCC_A_CFG) ? {24'h0, cfg_reg} :
      (paddr == TCC_A_FSEL) ? fsel_reg :
      (paddr == TCC_A_TBSEL) ? tbsel_reg :
      (paddr == TCC_A_HSR) ? {16'h0, hsr_reg} :
      (paddr == TCC_A_PRIO) ? prio_reg :
      (paddr == TCC_A_LINK) ? {16'h0, link_reg} :
      (paddr == TCC_A_STAT) ? stat_v : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
         cfg_reg <= TCC_CFG_RST;
         fsel_reg <= TCC_FSEL_RST;
         tbsel_reg <= TCC_TBSEL_RST;
         prio_reg <= TCC_PRIO_RST;
      end else begin
         pready_reg <= psel & penable & ~pready_reg;
         pslverr_reg <= psel & penable & ~pready_reg & ~addr_ok;
         prdata_reg <= (psel & penable & ~pready_reg & ~pwrite & addr_ok) ? rd_mux : 32'h0;
         if (host_wr && paddr == TCC_A_CFG) begin
            cfg_reg <= pwdata[7:0];
         end
         if (host_wr && paddr == TCC_A_FSEL) begin
            fsel_reg <= pwdata;
         end
         if (host_wr && paddr == TCC_A_TBSEL) begin
            tbsel_reg <= pwdata;
         end
         if (host_wr && paddr == TCC_A_PRIO) begin
            prio_reg <= pwdata;
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign ch_pin_o = pin_o_reg;
   assign ch_pin_oe = pin_oe_reg;
   assign ucode_from_ram = ucode_reg;

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_tb1_count: assert property (tb1_tick |=> tb1_reg == $past(tb1_reg) + 16'h0001)
      else $error("Primary time base missed a tick.");
   chk_tb1_hold: assert property (!tb1_tick |=> $stable(tb1_reg))
      else $error("Primary time base moved without a prescaler tick.");
   chk_grant_take: assert property (svc_start |=> st_reg == TCC_ST_FETCH && ch_reg == $past(pick))
      else $error("Grant did not hand the winner to the engine.");
   chk_one_service: assert property (svc_start |=> !svc_start [*2] ##1 st_reg == TCC_ST_IDLE)
      else $error("New grant issued during a service.");
   chk_level_order: assert property (svc_start && (|m_hi) |-> pri[pick] == TCC_PRI_HIGH)
      else $error("Lower level granted while a high request waits.");
   chk_match_flag: assert property (|match_hit |=> (mflag_reg & $past(match_hit)) == $past(match_hit))
      else $error("Match event not recorded.");
   chk_cap_latch: assert property (cap_edge[7] |=> cap_reg[7] == $past(ctb[7]))
      else $error("Capture register missed the time base.");
   chk_apb_wait: assert property (psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg)
      else $error("Bus answer not one wait state long.");
   chk_ram_pair: assert property (host_wr && ram_hit && !eng_wr |=> ram[$past(paddr[7:2])] == $past(pwdata))
      else $error("Parameter pair not written together.");
   chk_dir_engine: assert property ($changed(pin_oe_reg) |-> $past(in_exec))
      else $error("Pin direction changed outside engine execution.");

   cov_two_levels: cover property (svc_start && (|m_hi) && (|m_low));
   cov_rr_same_level: cover property (svc_start ##3 svc_start && $past(lvl, 3) == lvl);
   cov_capture: cover property (cap_edge[7] ##[1:20] svc_start);
   cov_link: cover property (do_link ##[1:10] svc_start);
endmodule : tcc_top
`default_nettype wire

/* File: tb/tcc_pin_env.sv */
// Pin-side model of the coprocessor: channel input levels and the external time base clock.
`timescale 1ns/100ps
`default_nettype none
module tcc_pin_env (
   // Clock.
   input wire logic pclk,
   // Pin levels from the design.
   input wire logic [15:0] ch_pin_o,
   input wire logic [15:0] ch_pin_oe,
   // Pin levels to the design.
   output logic [15:0] ch_pin_i,
   output logic external_time_base_clock_pin
);
   // ==========================================================
   // Pin wires
   logic [15:0] drive_lvl;
   initial begin
      drive_lvl = 16'h0000;
      external_time_base_clock_pin = 1'b0;
   end
   // A pin that the engine drives reads back its own level, otherwise the outside level.
   assign ch_pin_i = (ch_pin_oe & ch_pin_o) | (~ch_pin_oe & drive_lvl);
   // ==========================================================
   // Stimulus tasks
   // Several pins may rise on one edge, so events on many channels coincide.
   task automatic raise(input logic [15:0] m);
      drive_lvl <= drive_lvl | m;
   endtask : raise
   // The external clock stands still outside these bursts; each phase lasts four cycles to survive the synchroniser.
   task automatic ext_pulses(input int cnt);
      repeat (cnt) begin
         repeat (4) @(posedge pclk);
         external_time_base_clock_pin <= 1'b1;
         repeat (4) @(posedge pclk);
         external_time_base_clock_pin <= 1'b0;
      end
   endtask : ext_pulses
endmodule : tcc_pin_env
`default_nettype wire

/* File: tb/tcc_top_bench.sv */
// Self-checking testbench of the timer channel coprocessor core.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected at %0t: %s got %0h exp %0h", $time, m, g, e); end end
module tcc_top_bench;
   import tcc_pkg::*;
   // ==========================================================
   // Signals
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ucode_from_ram, ext_clk, perr;
   logic saw_ram = 1'b0;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, r2;
   logic [15:0] pin_i, pin_o, pin_oe, oe_q;
   logic [11:0] rst_a [4] = '{TCC_A_CFG, TCC_A_FSEL, TCC_A_TBSEL, TCC_A_PRIO};
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;
   int ord[$];
   int ord_t[$];
   // ==========================================================
   // Design and pin model
   tcc_top #(.NCH(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_pin_i(pin_i),
      .ch_pin_o(pin_o), .ch_pin_oe(pin_oe), .external_time_base_clock_pin(ext_clk),
      .ucode_from_ram(ucode_from_ram));
   tcc_pin_env env (.pclk(pclk), .ch_pin_o(pin_o), .ch_pin_oe(pin_oe), .ch_pin_i(pin_i),
      .external_time_base_clock_pin(ext_clk));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Grants show as the output enable of a channel rising; the order and spacing are recorded.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      oe_q <= pin_oe;
      if (ucode_from_ram === 1'b1) saw_ram <= 1'b1;
      for (int i = 0; i < 16; i++) if (pin_oe[i] === 1'b1 && oe_q[i] !== 1'b1) begin
         ord.push_back(i);
         ord_t.push_back(cyc);
      end
   end
   // ==========================================================
   // Bus tasks
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rdv,
                      output logic err);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) `CHK(pready, 1'b1, "bus answer missing")
      // One idle edge keeps two transfers from assigning the strobes in one time step.
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1'b1, a, d, x, e);
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] x);
      logic e;
      apb(1'b0, a, 32'h0, x, e);
   endtask : rd
   task automatic wait_sig(input int ch, input logic use_oe, input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (((use_oe ? pin_oe[ch] : pin_o[ch]) !== lvl) && cnt < lim) begin
         @(posedge pclk);
         cnt++;
      end
   endtask : wait_sig
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   initial begin
      #60000;
      num_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      complete_run;
   end
   // ==========================================================
   // Tests
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 4; i++) begin
         rd(rst_a[i], r);
         `CHK(r, 32'h0, "reset value")
      end
      apb(1'b0, 12'h0fc, 32'h0, r, perr);
      `CHK({perr, r}, 33'h1_0000_0000, "unmapped read")
      wr(TCC_A_CFG, 32'h0000_00ff);
      rd(TCC_A_CFG, r);
      `CHK(r, 32'h0000_00ff, "config readback")
      $display("test registers done");
      wr(12'h100, 32'h1234_abcd);
      wr(12'h1fc, 32'hcafe_0001);
      rd(12'h100, r);
      rd(12'h1fc, r2);
      `CHK({r, r2}, 64'h1234_abcd_cafe_0001, "parameter pair")
      $display("test parameter ram done");
      wr(12'h124, 32'h0010_0000);
      wr(TCC_A_CFG, 32'h0000_0080);
      wr(TCC_A_FSEL, 32'h0000_0040);
      wr(TCC_A_PRIO, 32'h0000_00c0);
      wr(TCC_A_HSR, 32'h0000_0008);
      wait_sig(3, 1'b1, 1'b1, 20, n);
      `CHK(pin_oe[3], 1'b1, "host request grant")
      wait_sig(3, 1'b0, 1'b1, 80, n);
      `CHK(pin_o[3], 1'b1, "match toggle")
      rd(TCC_A_STAT, r);
      `CHK(r[3:0], 4'h3, "serviced channel")
      `CHK(saw_ram, 1'b1, "microcode source")
      $display("test host service done");
      wr(12'h118, 32'h0100_0000);
      wr(12'h13c, 32'h0100_0000);
      wr(12'h16c, 32'h0100_0000);
      wr(TCC_A_FSEL, 32'h0004_0410);
      wr(TCC_A_PRIO, 32'h000c_0c10);
      ord.delete();
      ord_t.delete();
      wr(TCC_A_HSR, 32'h0000_0224);
      repeat (40) @(posedge pclk);
      `CHK(ord.size(), 3, "grant count")
      if (ord.size() == 3) begin
         `CHK({ord[0], ord[1], ord[2]}, {32'd5, 32'd9, 32'd2}, "grant order")
         `CHK(ord_t[1] - ord_t[0] >= 3 && ord_t[2] - ord_t[1] >= 3, 1'b1, "grant spacing")
      end
      $display("test arbitration done");
      wr(12'h154, 32'h0000_dead);
      wr(12'h160, 32'h0000_dead);
      wr(12'h1b8, 32'h0000_dead);
      wr(TCC_A_FSEL, 32'h8006_8410);
      wr(TCC_A_PRIO, 32'h800e_8c10);
      env.raise(16'h8180);
      repeat (60) @(posedge pclk);
      rd(12'h154, r);
      rd(12'h160, r2);
      `CHK(r[15:0], r2[15:0], "simultaneous capture")
      rd(12'h1b8, r2);
      `CHK(r2[15:0], r[15:0], "wide channel parameter slot")
      `CHK(r[15:0] !== 16'hdead, 1'b1, "capture stored")
      $display("test capture done");
      wr(12'h184, 32'h0004_0000);
      wr(TCC_A_CFG, 32'h0000_0040);
      wr(TCC_A_TBSEL, 32'h0000_0800);
      wr(TCC_A_FSEL, 32'h0046_8410);
      wr(TCC_A_PRIO, 32'h00ce_8c10);
      wr(TCC_A_HSR, 32'h0000_0800);
      repeat (100) @(posedge pclk);
      `CHK(pin_o[11], 1'b0, "secondary base held")
      // Six edges pass the first match but stop short of the re-armed one, so the pin stays high.
      env.ext_pulses(6);
      wait_sig(11, 1'b0, 1'b1, 60, n);
      `CHK(pin_o[11], 1'b1, "secondary match")
      $display("test external time base done");
      complete_run;
   end
endmodule : tcc_top_bench
`default_nettype wire
